// *** hw/cfc_fetch_timing.sv ***
// Instruction fetch and execute timing controller
// Assumes a decoder that classifies the byte on CODE_BYTE_IN in the same cycle
//
// How it works
// - Fast mode fetches one code byte on every system clock.
// - Fetch of the next byte overlaps execution of the current one.
// - Fast mode is selected only when the compatibility fuse reads cleared at the end of boot.
// - Instructions are one to three bytes long.
// - Fast mode instructions take as many clocks as bytes.
// - Fast mode branches take one extra slot; complex ones take several extra.
// - Fast mode code from external memory takes three times as long.
// - Compatibility mode is the default and follows a set fuse.
// - Compatibility mode fetches a byte every third clock.
// - Machine cycle is six states of two clocks, twelve clocks.
// - Compatibility instructions take one, two or four machine cycles.
// - Compatibility timing ignores internal or external code memory.
`include "cfc_consts.svh"
module cfc_fetch_timing
    import cfc_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    // Configuration
    input wire logic COMPAT_FUSE_IN,
    // Code memory
    input wire logic CODE_EXT_IN,
    input wire logic [7:0] CODE_BYTE_IN,
    // Decoder
    input wire logic [1:0] INSN_LEN_IN,
    input wire logic [1:0] INSN_KIND_IN,
    input wire logic [3:0] INSN_XCYC_IN,
    input wire logic [1:0] INSN_MCYC_IN,
    // Fetch stage
    output logic FETCH_OUT,
    output logic FETCH_OPC_OUT,
    // Execute stage
    output logic EXEC_VALID_OUT,
    output logic [7:0] EXEC_BYTE_OUT,
    output logic INSN_DONE_OUT,
    // Status
    output logic RUN_OUT,
    output logic FAST_MODE_OUT,
    output logic [2:0] MSTATE_OUT,
    output logic MPHASE_OUT
);
    logic fuse_lvl;
    cfc_phase_e ph_q, ph_d;
    logic [2:0] boot_q, boot_d;
    logic fast_q, fast_d;
    logic [5:0] left_q, left_d;
    logic [1:0] bytes_q, bytes_d;
    logic [1:0] slot_q, slot_d;
    logic [1:0] per_q, per_d;
    logic fetch_q, fetch_d;
    logic opc_q, opc_d;
    logic done_q, done_d;
    logic xv_q, xv_d;
    logic [7:0] ir_q, ir_d;
    logic phase_q, phase_d;
    logic [2:0] st_q, st_d;
    logic run, start, done;
    logic [1:0] len;
    logic [1:0] per_new;
    logic [4:0] nslots;
    logic [6:0] total;

    // ----------------------------------------
    // Fuse synchroniser
    // ----------------------------------------
    cfc_sync3 u_fuse_sync
    (
        .clk_in(MCLK_IN),
        .rst_n_in(RST_N_IN),
        .level_in(COMPAT_FUSE_IN),
        .level_out(fuse_lvl)
    );

    // ----------------------------------------
    // Mode latch after reset
    // ----------------------------------------
    always_comb
    begin
        ph_d = ph_q;
        boot_d = boot_q;
        fast_d = fast_q;
        unique case (ph_q)
            CFC_BOOT:
            begin
                boot_d = 3'(boot_q + 3'h1);
                if (boot_q == `CFC_BOOT_CYC)
                begin
                    fast_d = ~fuse_lvl;
                    ph_d = CFC_RUN;
                end
            end
            CFC_RUN:
            begin
                fast_d = fast_q;
            end
        endcase
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            ph_q <= CFC_BOOT;
            boot_q <= 3'h0;
            fast_q <= `CFC_MODE_RST;
        end
        else
        begin
            ph_q <= ph_d;
            boot_q <= boot_d;
            fast_q <= fast_d;
        end
    end

    // ----------------------------------------
    // Instruction cycle budget
    // ----------------------------------------
    always_comb
    begin
        run = (ph_q == CFC_RUN);
        start = run && (left_q == 6'h0);
        len = (INSN_LEN_IN == 2'h0) ? 2'h1 : INSN_LEN_IN;
        nslots = {3'h0, len};
        if (INSN_KIND_IN == CFC_K_BRANCH)
        begin
            nslots = 5'(nslots + {1'b0, `CFC_BRANCH_XTRA});
        end
        else if (INSN_KIND_IN == CFC_K_COMPLEX)
        begin
            nslots = 5'(nslots + {1'b0, INSN_XCYC_IN});
        end
        if (fast_q)
        begin
            per_new = CODE_EXT_IN ? `CFC_PER_EXT : `CFC_PER_FAST;
            total = 7'(nslots * per_new);
        end
        else
        begin
            per_new = `CFC_PER_CMP;
            unique case (INSN_MCYC_IN)
                2'h0: total = `CFC_MCYC_CLK;
                2'h1: total = 7'(`CFC_MCYC_CLK * 7'h2);
                default: total = 7'(`CFC_MCYC_CLK * 7'h4);
            endcase
        end
        done = start ? (total == 7'h1) : (run && left_q == 6'h1);
    end

    // ----------------------------------------
    // Fetch sequencing and pipeline
    // ----------------------------------------
    always_comb
    begin
        left_d = left_q;
        bytes_d = bytes_q;
        slot_d = slot_q;
        per_d = per_q;
        ir_d = ir_q;
        if (start)
        begin
            left_d = 6'(total - 7'h1);
            bytes_d = 2'(len - 2'h1);
            per_d = per_new;
            slot_d = (per_new == 2'h1) ? 2'h0 : 2'h1;
        end
        else if (run)
        begin
            left_d = 6'(left_q - 6'h1);
            slot_d = (slot_q == 2'(per_q - 2'h1)) ? 2'h0 : 2'(slot_q + 2'h1);
            if (slot_q == 2'h0 && bytes_q != 2'h0)
            begin
                bytes_d = 2'(bytes_q - 2'h1);
            end
        end
        // Next cycle is a fetch when an opcode is due or operand bytes remain
        opc_d = (ph_d == CFC_RUN) && (left_d == 6'h0);
        fetch_d = opc_d || ((ph_d == CFC_RUN) && slot_d == 2'h0 && bytes_d != 2'h0);
        // Execute stage holds the byte fetched one cycle earlier
        if (fetch_q)
        begin
            ir_d = CODE_BYTE_IN;
        end
        xv_d = fetch_q;
        done_d = done;
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            left_q <= 6'h0;
            bytes_q <= 2'h0;
            slot_q <= 2'h0;
            per_q <= `CFC_PER_CMP;
            fetch_q <= 1'b0;
            opc_q <= 1'b0;
            done_q <= 1'b0;
            xv_q <= 1'b0;
            ir_q <= 8'h00;
        end
        else
        begin
            left_q <= left_d;
            bytes_q <= bytes_d;
            slot_q <= slot_d;
            per_q <= per_d;
            fetch_q <= fetch_d;
            opc_q <= opc_d;
            done_q <= done_d;
            xv_q <= xv_d;
            ir_q <= ir_d;
        end
    end

    // ----------------------------------------
    // Machine cycle states on the halved clock
    // ----------------------------------------
    always_comb
    begin
        phase_d = 1'b0;
        st_d = 3'h0;
        if (run && !fast_q)
        begin
            phase_d = ~phase_q;
            st_d = st_q;
            if (phase_q)
            begin
                st_d = (st_q == `CFC_LAST_STATE) ? 3'h0 : 3'(st_q + 3'h1);
            end
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            phase_q <= 1'b0;
            st_q <= 3'h0;
        end
        else
        begin
            phase_q <= phase_d;
            st_q <= st_d;
        end
    end

    assign FETCH_OUT = fetch_q;
    assign FETCH_OPC_OUT = opc_q;
    assign EXEC_VALID_OUT = xv_q;
    assign EXEC_BYTE_OUT = ir_q;
    assign INSN_DONE_OUT = done_q;
    assign RUN_OUT = ph_q[1];
    assign FAST_MODE_OUT = fast_q;
    assign MSTATE_OUT = st_q;
    assign MPHASE_OUT = phase_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_opcode_fetch: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        start |-> fetch_q && opc_q) else $error("opcode slot without fetch");
    a_pipe_byte: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        fetch_q |=> xv_q && ir_q == $past(CODE_BYTE_IN)) else $error("execute byte lost");
    a_mode_latch: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        ph_q == CFC_BOOT && boot_q == `CFC_BOOT_CYC |=> fast_q == !$past(fuse_lvl))
        else $error("mode not taken from fuse");
    a_mode_held: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        run |=> $stable(fast_q) && run) else $error("mode changed while running");
    a_boot_compat: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        ph_q == CFC_BOOT |-> !fast_q && !fetch_q) else $error("fast before latch");
    a_fast_bytes: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        start && fast_q && !CODE_EXT_IN && INSN_KIND_IN == CFC_K_PLAIN && INSN_LEN_IN == 2'h3
        |=> fetch_q [*2] ##1 start) else $error("fast length timing wrong");
    a_branch_xtra: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        start && fast_q && !CODE_EXT_IN && INSN_KIND_IN == CFC_K_BRANCH && INSN_LEN_IN == 2'h2
        |=> fetch_q ##1 !fetch_q ##1 start) else $error("branch extra cycle wrong");
    a_ext_triple: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        start && fast_q && CODE_EXT_IN && INSN_KIND_IN == CFC_K_PLAIN && INSN_LEN_IN == 2'h1
        |=> !start [*2] ##1 start) else $error("external slot not tripled");
    a_cmp_spacing: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        run && !fast_q && fetch_q |=> !fetch_q [*2]) else $error("compat fetch too soon");
    a_state_wrap: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        run && !fast_q && st_q == `CFC_LAST_STATE && phase_q |=> st_q == 3'h0 && !phase_q)
        else $error("state walk wrong");
    a_cmp_budget: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        start && !fast_q && INSN_MCYC_IN == 2'h1 |=> left_q == 6'h17)
        else $error("machine cycle budget wrong");
endmodule

// *** shared/cfc_consts.svh ***
// Constants of the fetch and execute timing controller
// Assumes inclusion by the controller only
`ifndef CFC_CONSTS_SVH
`define CFC_CONSTS_SVH

// ----------------------------------------
// Start-up
// ----------------------------------------
`define CFC_BOOT_CYC 3'h4
`define CFC_MODE_RST 1'h0

// ----------------------------------------
// Fetch slot periods in system clocks
// ----------------------------------------
`define CFC_PER_FAST 2'h1
`define CFC_PER_EXT 2'h3
`define CFC_PER_CMP 2'h3

// ----------------------------------------
// Machine cycle layout and fast mode branch extra slots
// ----------------------------------------
`define CFC_MCYC_CLK 7'h0c
`define CFC_LAST_STATE 3'h5
`define CFC_BRANCH_XTRA 4'h1

`endif

// *** shared/cfc_pkg.sv ***
// Types of the fetch and execute timing controller
// Assumes the constants header sits beside it
package cfc_pkg;

    // ----------------------------------------
    // Controller phases
    // ----------------------------------------
    typedef enum logic [1:0] {
        CFC_BOOT = 2'b01,
        CFC_RUN = 2'b10
    } cfc_phase_e;

    // ----------------------------------------
    // Instruction timing class from the decoder
    // ----------------------------------------
    typedef enum logic [1:0] {
        CFC_K_PLAIN = 2'h0,
        CFC_K_BRANCH = 2'h1,
        CFC_K_COMPLEX = 2'h2
    } cfc_kind_e;

endpackage

// *** hw/cfc_sync3.sv ***
// Three-stage synchroniser with agreement filter
// Assumes an asynchronous level input and an active-low asynchronous reset
module cfc_sync3
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Level
    input wire logic level_in,
    output logic level_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    logic lvl_d;

    always_comb
    begin
        lvl_d = lvl_q;
        if (s2_q == s3_q)
        begin
            lvl_d = s3_q;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
        end
        else
        begin
            s1_q <= level_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;
endmodule

// *** tb/cfc_code_mem.sv ***
// Code memory model: one byte for each fetch strobe, in address order
// Assumes the fetch strobe is launched by the controller's rising clock edge
module cfc_code_mem
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Fetch
    input wire logic fetch_in,
    output logic [7:0] byte_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] addr_q;
    logic [7:0] last_q;

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Idle bus shows the inverse of the last byte, never a stale copy
    assign byte_out = fetch_in ? (addr_q * 8'h1d + 8'h5a) : ~last_q;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            addr_q <= 8'h00;
            last_q <= 8'h00;
        end
        else if (fetch_in)
        begin
            addr_q <= addr_q + 8'h01;
            last_q <= byte_out;
        end
    end
endmodule

// *** tb/cfc_fetch_timing_tb.sv ***
// Self-checking bench of the fetch and execute timing controller
// Assumes the code memory model beside it; decoder inputs are driven here
module cfc_fetch_timing_tb
    import cfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic fuse = 1'b1;
    logic ext = 1'b0;
    logic [1:0] len = 2'h1;
    logic [1:0] kind = 2'h0;
    logic [3:0] xcyc = 4'h0;
    logic [1:0] mcyc = 2'h0;
    logic [7:0] code;
    logic fetch, opc, exec_v, done, run, fast, mph;
    logic [7:0] xbyte;
    logic [2:0] mst;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    // ----------------------------------------
    // Clock, timeout and instances
    // ----------------------------------------
    always #5 mclk = ~mclk;

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    cfc_fetch_timing DUT (.MCLK_IN(mclk), .RST_N_IN(rst_n), .COMPAT_FUSE_IN(fuse),
        .CODE_EXT_IN(ext), .CODE_BYTE_IN(code), .INSN_LEN_IN(len), .INSN_KIND_IN(kind),
        .INSN_XCYC_IN(xcyc), .INSN_MCYC_IN(mcyc), .FETCH_OUT(fetch), .FETCH_OPC_OUT(opc),
        .EXEC_VALID_OUT(exec_v), .EXEC_BYTE_OUT(xbyte), .INSN_DONE_OUT(done),
        .RUN_OUT(run), .FAST_MODE_OUT(fast), .MSTATE_OUT(mst), .MPHASE_OUT(mph));

    cfc_code_mem u_mem (.clk_in(mclk), .rst_n_in(rst_n), .fetch_in(fetch), .byte_out(code));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic do_reset(input logic fuse_v);
        int n;
        @(negedge mclk);
        rst_n = 1'b0;
        fuse = fuse_v;
        repeat (20) @(negedge mclk);
        check(8'(run), 8'h00);
        check(8'(fast), 8'h00);
        rst_n = 1'b1;
        n = 0;
        while (run !== 1'b1 && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        check(8'(n), 8'h05);
        check(8'(fast), 8'(!fuse_v));
        check(8'(opc), 8'h01);
    endtask

    // One instruction from its opcode cycle to the next opcode cycle
    task automatic run_insn(input logic [1:0] l, input logic [1:0] k, input logic [3:0] x,
        input logic [1:0] m, input logic e, input int p, input int t);
        int c;
        logic prev;
        logic [7:0] pbyte;
        len = l;
        kind = k;
        xcyc = x;
        mcyc = m;
        ext = e;
        c = 0;
        while (opc !== 1'b1 && c < 100)
        begin
            @(negedge mclk);
            c++;
        end
        prev = 1'b0;
        pbyte = 8'h00;
        for (c = 0; c <= t; c++)
        begin
            if (c > 0)
            begin
                check(8'(exec_v), 8'(prev));
                if (prev === 1'b1)
                    check(xbyte, pbyte);
                check(8'(done), 8'(c == t));
                check(8'(opc), 8'(c == t));
            end
            if (c < t)
                check(8'(fetch), 8'((c % p == 0) && (c / p < l)));
            check(8'(mst), (fast === 1'b1) ? 8'h00 : 8'((c / 2) % 6));
            check(8'(mph), (fast === 1'b1) ? 8'h00 : 8'(c % 2));
            prev = fetch;
            pbyte = code;
            if (c < t)
                @(negedge mclk);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_compat_timing();
        do_reset(1'b1);
        run_insn(2'h1, 2'h0, 4'h0, 2'h0, 1'b0, 3, 12);
        run_insn(2'h2, 2'h0, 4'h0, 2'h1, 1'b0, 3, 24);
        run_insn(2'h3, 2'h0, 4'h0, 2'h2, 1'b0, 3, 48);
        run_insn(2'h3, 2'h1, 4'h0, 2'h3, 1'b0, 3, 48);
    endtask

    task automatic test_compat_ext();
        run_insn(2'h2, 2'h0, 4'h0, 2'h1, 1'b1, 3, 24);
        run_insn(2'h3, 2'h2, 4'h5, 2'h2, 1'b1, 3, 48);
    endtask

    task automatic test_compat_hold();
        fuse = 1'b0;
        run_insn(2'h1, 2'h0, 4'h0, 2'h0, 1'b0, 3, 12);
        run_insn(2'h1, 2'h0, 4'h0, 2'h0, 1'b0, 3, 12);
        check(8'(fast), 8'h00);
    endtask

    task automatic test_fast_plain();
        do_reset(1'b0);
        run_insn(2'h1, 2'h0, 4'h0, 2'h0, 1'b0, 1, 1);
        run_insn(2'h1, 2'h3, 4'h0, 2'h0, 1'b0, 1, 1);
        run_insn(2'h2, 2'h0, 4'h0, 2'h2, 1'b0, 1, 2);
        run_insn(2'h3, 2'h0, 4'h0, 2'h0, 1'b0, 1, 3);
        run_insn(2'h3, 2'h3, 4'h9, 2'h0, 1'b0, 1, 3);
    endtask

    task automatic test_fast_branch();
        run_insn(2'h2, 2'h1, 4'h0, 2'h0, 1'b0, 1, 3);
        run_insn(2'h1, 2'h2, 4'h3, 2'h0, 1'b0, 1, 4);
        run_insn(2'h3, 2'h1, 4'h0, 2'h0, 1'b0, 1, 4);
    endtask

    task automatic test_fast_ext();
        run_insn(2'h2, 2'h0, 4'h0, 2'h0, 1'b1, 3, 6);
        run_insn(2'h2, 2'h1, 4'h0, 2'h0, 1'b1, 3, 9);
        run_insn(2'h1, 2'h2, 4'h2, 2'h0, 1'b1, 3, 9);
        run_insn(2'h1, 2'h0, 4'h0, 2'h0, 1'b1, 3, 3);
        run_insn(2'h1, 2'h0, 4'h0, 2'h0, 1'b0, 1, 1);
    endtask

    task automatic test_fast_hold();
        fuse = 1'b1;
        run_insn(2'h1, 2'h0, 4'h0, 2'h0, 1'b0, 1, 1);
        run_insn(2'h2, 2'h0, 4'h0, 2'h0, 1'b0, 1, 2);
        check(8'(fast), 8'h01);
    endtask

    initial
    begin
        test_compat_timing();
        test_compat_ext();
        test_compat_hold();
        test_fast_plain();
        test_fast_branch();
        test_fast_ext();
        test_fast_hold();
        end_of_test();
    end
endmodule
